/* dv/dcp_ctlr_model.sv */
// ********
// Controller model
// ********
module dcp_ctlr_model (
  // Pacing clock
  input wire clk,
  // Command pins
  output logic ck,
  output logic ck_n,
  output logic cke,
  output logic cs_n,
  output logic [2:0] cmd,
  output logic [2:0] ba,
  output logic [13:0] addr,
  output logic odt,
  // Write pins
  output logic [7:0] dq,
  output logic dqs,
  output logic dm
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    {ck, ck_n, cke, cs_n} = 4'h7;
    {cmd, ba, addr, odt, dq, dqs, dm} = {3'h7, 28'h0};
  end

  // Pins held 4 cycles each side of the rise, past the 2-cycle sync
  task automatic cyc(input logic s, input logic [2:0] c,
                     input logic [2:0] b, input logic [13:0] a);
    cs_n = ~s;
    cmd = c;
    ba = b;
    addr = a;
    repeat (4) @(posedge clk);
    #1 {ck, ck_n} = 2'h2;
    repeat (4) @(posedge clk);
    #1 {ck, ck_n} = 2'h1;
  endtask

  // Only changed between accesses, never inside one
  task automatic pins(input logic e, input logic o);
    cke = e;
    odt = o;
  endtask

  task automatic wburst(input logic [31:0] d, input logic [3:0] m);
    for (int i = 0; i < 4; i++) begin
      dq = d[8*i +: 8];
      dm = m[i];
      dqs = ~dqs;
      repeat (4) @(posedge clk);
      #1;
    end
    // Released lines must not keep the last beat
    dq = ~dq;
    dm = ~dm;
  endtask
endmodule // dcp_ctlr_model

/* dv/dcp_ctrl_pins_tb_top.sv */
`include "dcp_defines.vh"

// ********
// Bench top
// ********
module dcp_ctrl_pins_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock, nrst, oe_d, dqs_d, rdqs_seen;
  wire ck, ck_n, cke, cs_n, odt, dqs, dm, dq_oe, dqs_out, rdqs_oe;
  wire t_dq, t_dqs, t_dm, cmd_valid, wr_beat, wr_keep;
  wire [2:0] cmd, ba, cmd_code;
  wire [13:0] addr;
  wire [7:0] dq, dq_out, wr_data, bank_open;
  wire [5:0] en;
  wire [1:0] pwr;
  int mismatches, n_tests, n_cmd, k;
  logic [2:0] last_code;
  logic [8:0] wq[$];
  logic [7:0] rq[$];

  dcp_ctrl_pins #(.LANES(1)) i_dcp_ctrl_pins (
    .CLOCK(clock), .NRST(nrst), .CK(ck), .CK_N(ck_n), .CKE(cke),
    .CS_N(cs_n), .RAS_N(cmd[2]), .CAS_N(cmd[1]), .WE_N(cmd[0]), .BA(ba),
    .ADDR(addr), .ODT(odt), .DQ_IN(dq), .DQ_OUT(dq_out), .DQ_OE(dq_oe),
    .DQS_IN(dqs), .DQS_OUT(dqs_out), .DQS_N_OUT(), .DQS_OE(),
    .DM_IN(dm), .RDQS_OUT(), .RDQS_N_OUT(), .RDQS_OE(rdqs_oe),
    .TERM_DQ_EN(t_dq), .TERM_DQS_EN(t_dqs), .TERM_DM_EN(t_dm),
    .INT_CLK_EN(en[5]), .OUT_DRV_EN(en[4]), .BUF_CLK_EN(en[3]),
    .BUF_CMD_EN(en[2]), .BUF_ODT_EN(en[1]), .BUF_CKE_EN(en[0]),
    .PWR_STATE(pwr), .BANK_OPEN(bank_open), .CMD_VALID(cmd_valid),
    .CMD_CODE(cmd_code), .WR_BEAT(wr_beat), .WR_DATA(wr_data),
    .WR_KEEP(wr_keep));
  dcp_ctlr_model i_dcp_ctlr_model (
    .clk(clock), .ck(ck), .ck_n(ck_n), .cke(cke), .cs_n(cs_n), .cmd(cmd),
    .ba(ba), .addr(addr), .odt(odt), .dq(dq), .dqs(dqs), .dm(dm));

  initial begin
    clock = 0;
    forever #5 clock = ~clock;
  end

  // Pulses are logged as they occur so no beat is lost between checks
  always @(posedge clock) begin
    if (cmd_valid === 1'b1) begin
      n_cmd++;
      last_code = cmd_code;
    end
    if (wr_beat === 1'b1) wq.push_back({wr_keep, wr_data});
    if (dq_oe === 1'b1 && (oe_d !== 1'b1 || dqs_out !== dqs_d))
      rq.push_back(dq_out);
    oe_d = dq_oe;
    dqs_d = dqs_out;
    if (rdqs_oe === 1'b1) rdqs_seen = 1;
  end

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic check(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cyc(input logic s, input logic [2:0] c,
                     input logic [2:0] b, input logic [13:0] a);
    // Back to back calls give CK a period of 80 ns
    i_dcp_ctlr_model.cyc(s, c, b, a);
  endtask

  task automatic want_pwr(input logic [1:0] s, input logic [5:0] b);
    for (k = 0; k < 10 && pwr !== s; k++) tick(1);
    check("power state", s, pwr);
    check("buffer enables", b, en);
    if (pwr !== s) wrap_up;
  endtask

  task automatic rd_chk(input logic [7:0] seed);
    check("read beats", 16'h4, rq.size());
    for (int i = 0; i < 4; i++) check("read data", seed + i, rq[i]);
  endtask

  task automatic wr_chk(input logic [31:0] d, input logic [3:0] m);
    check("write beats", 16'h4, wq.size());
    for (int i = 0; i < 4; i++)
      check("write beat", {~m[i], d[8*i +: 8]}, wq[i]);
  endtask

  task automatic t_select;
    cyc(1'b0, `DCP_CMD_ACT, 3'h3, 14'h0);
    check("masked count", 16'h0, n_cmd);
    check("masked banks", 16'h0, bank_open);
    cyc(1'b1, `DCP_CMD_ACT, 3'h3, 14'h0);
    check("command code", `DCP_CMD_ACT, last_code);
    check("open banks", 16'h8, bank_open);
    $display("select test done");
  endtask

  task automatic t_odt;
    i_dcp_ctlr_model.pins(1'b1, 1'b1);
    cyc(1'b1, `DCP_CMD_NOP, 3'h0, 14'h0);
    check("term gated", 16'h0, {t_dq, t_dqs, t_dm});
    cyc(1'b1, `DCP_CMD_MRS, `DCP_BA_EMR1, 14'h4);
    cyc(1'b1, `DCP_CMD_NOP, 3'h0, 14'h0);
    check("term on", 16'h7, {t_dq, t_dqs, t_dm});
    i_dcp_ctlr_model.pins(1'b1, 1'b0);
    cyc(1'b1, `DCP_CMD_NOP, 3'h0, 14'h0);
    check("term off", 16'h0, {t_dq, t_dqs, t_dm});
    $display("termination test done");
  endtask

  task automatic t_rw(input logic [2:0] b, input logic [7:0] a,
                      input logic [31:0] d, input logic [3:0] m);
    rq.delete();
    wq.delete();
    cyc(1'b1, `DCP_CMD_RD, b, {6'h0, a});
    repeat (5) cyc(1'b1, `DCP_CMD_NOP, 3'h0, 14'h0);
    rd_chk(a);
    cyc(1'b1, `DCP_CMD_WR, b, 14'h0);
    i_dcp_ctlr_model.wburst(d, m);
    tick(4);
  endtask

  task automatic t_power;
    i_dcp_ctlr_model.pins(1'b0, 1'b0);
    cyc(1'b1, `DCP_CMD_NOP, 3'h0, 14'h0);
    want_pwr(`DCP_PS_APD, 6'h0b);
    cyc(1'b1, `DCP_CMD_PRE, 3'h0, 14'h0400);
    check("banks held", 16'h8, bank_open);
    i_dcp_ctlr_model.pins(1'b1, 1'b0);
    cyc(1'b1, `DCP_CMD_NOP, 3'h0, 14'h0);
    want_pwr(`DCP_PS_ACT, 6'h3f);
    cyc(1'b1, `DCP_CMD_PRE, 3'h0, 14'h0400);
    i_dcp_ctlr_model.pins(1'b0, 1'b0);
    cyc(1'b1, `DCP_CMD_NOP, 3'h0, 14'h0);
    want_pwr(`DCP_PS_PPD, 6'h0b);
    cyc(1'b1, `DCP_CMD_REF, 3'h0, 14'h0);
    i_dcp_ctlr_model.pins(1'b1, 1'b0);
    cyc(1'b1, `DCP_CMD_NOP, 3'h0, 14'h0);
    want_pwr(`DCP_PS_ACT, 6'h3f);
    // Termination requested on entry, so the forced-off path is exercised
    i_dcp_ctlr_model.pins(1'b0, 1'b1);
    cyc(1'b1, `DCP_CMD_REF, 3'h0, 14'h0);
    want_pwr(`DCP_PS_SREF, 6'h01);
    check("term in self refresh", 16'h0, {t_dq, t_dqs, t_dm});
    // No CK from here: the exit has to work on CKE alone
    i_dcp_ctlr_model.pins(1'b1, 1'b0);
    want_pwr(`DCP_PS_ACT, 6'h3f);
    $display("power test done");
  endtask

  initial begin
    nrst = 0;
    rdqs_seen = 0;
    repeat (12) @(posedge clock);
    #1;
    nrst = 1;
    tick(3);
    check("reset enables", 16'h3f, en);
    check("reset code", `DCP_CMD_NOP, cmd_code);
    t_select;
    t_odt;
    t_rw(3'h3, 8'h40, 32'h4433_2211, 4'h2);
    wr_chk(32'h4433_2211, 4'h2);
    check("strobe option off", 16'h0, rdqs_seen);
    $display("mask mode test done");
    t_power;
    cyc(1'b1, `DCP_CMD_MRS, `DCP_BA_EMR1, 14'h0804);
    cyc(1'b1, `DCP_CMD_ACT, 3'h1, 14'h0);
    t_rw(3'h1, 8'h10, 32'hddcc_bbaa, 4'hf);
    wr_chk(32'hddcc_bbaa, 4'h0);
    check("strobe option on", 16'h1, rdqs_seen);
    $display("read strobe test done");
    wrap_up;
  end

  initial begin
    #200000;
    mismatches++;
    wrap_up;
  end
endmodule // dcp_ctrl_pins_tb_top

/* dv/dcp_props.sv */
`include "dcp_defines.vh"

// ********
// Pin checker
// ********
module dcp_props #(
  parameter LANES = 1
) (
  // Clock and reset
  input wire CLOCK,
  input wire NRST,
  // Command pins
  input wire CK,
  input wire CKE,
  input wire CS_N,
  input wire RAS_N,
  input wire CAS_N,
  input wire WE_N,
  input wire ODT,
  // Read drive
  input wire [8*LANES-1:0] DQ_OUT,
  input wire DQ_OE,
  input wire [LANES-1:0] DQS_OUT,
  input wire [LANES-1:0] DQS_N_OUT,
  input wire DQS_OE,
  input wire RDQS_OUT,
  input wire RDQS_OE,
  // Termination, power, commands
  input wire TERM_DQ_EN,
  input wire [LANES-1:0] TERM_DQS_EN,
  input wire [LANES-1:0] TERM_DM_EN,
  input wire INT_CLK_EN,
  input wire OUT_DRV_EN,
  input wire BUF_CLK_EN,
  input wire BUF_CMD_EN,
  input wire BUF_ODT_EN,
  input wire BUF_CKE_EN,
  input wire [1:0] PWR_STATE,
  input wire [7:0] BANK_OPEN,
  input wire CMD_VALID,
  input wire [2:0] CMD_CODE
);
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!NRST);

  // NOP left out: whether it pulses is left open
  sequence s_sel_rise;
    $rose(CK) && !CS_N && CKE && PWR_STATE == `DCP_PS_ACT &&
      {RAS_N, CAS_N, WE_N} != `DCP_CMD_NOP;
  endsequence
  sequence s_desel_rise;
    $rose(CK) && CS_N;
  endsequence

  chk_sel_exec: assert property (
    s_sel_rise |-> ##[2:4] (CMD_VALID && CMD_CODE == {RAS_N, CAS_N, WE_N}))
    else $error("command not executed");
  chk_desel_quiet: assert property (
    s_desel_rise |-> (!CMD_VALID && $stable(BANK_OPEN)) [*5])
    else $error("deselected command acted");
  chk_active_run: assert property (
    PWR_STATE == `DCP_PS_ACT |-> INT_CLK_EN && OUT_DRV_EN && BUF_CMD_EN)
    else $error("active state gated");
  chk_pd_bufs: assert property (
    PWR_STATE inside {`DCP_PS_PPD, `DCP_PS_APD} |-> !INT_CLK_EN &&
      !OUT_DRV_EN && !BUF_CMD_EN && BUF_CLK_EN && BUF_ODT_EN && BUF_CKE_EN)
    else $error("power-down buffers wrong");
  chk_sref_bufs: assert property (
    PWR_STATE == `DCP_PS_SREF |-> (!BUF_CLK_EN && !BUF_ODT_EN &&
      !BUF_CMD_EN && BUF_CKE_EN) ##1 !TERM_DQ_EN)
    else $error("self refresh buffers wrong");
  chk_pd_kind: assert property (
    $past(PWR_STATE) == `DCP_PS_ACT && PWR_STATE != `DCP_PS_ACT |->
      (PWR_STATE == `DCP_PS_APD) == (BANK_OPEN != 8'h00))
    else $error("wrong power-down kind");
  chk_sref_exit: assert property (
    PWR_STATE == `DCP_PS_SREF && CKE |-> ##[1:4] (PWR_STATE == `DCP_PS_ACT))
    else $error("self refresh exit late");
  chk_term_cause: assert property (
    $rose(TERM_DQ_EN) |-> ODT && &TERM_DQS_EN && &TERM_DM_EN)
    else $error("termination without request");
  chk_rd_strobe: assert property (
    DQ_OE |-> DQS_OE && DQS_N_OUT == ~DQS_OUT &&
      (!RDQS_OE || RDQS_OUT == DQS_OUT[0]))
    else $error("read strobes disagree");
  chk_rd_ddr: assert property (
    DQ_OE && $past(DQ_OE) && $changed(DQ_OUT) |-> $changed(DQS_OUT))
    else $error("read beat off strobe");
endmodule // dcp_props

bind dcp_ctrl_pins dcp_props #(.LANES(LANES)) i_dcp_props (.*);

/* verilog/dcp_ctrl_pins.v */
`include "dcp_defines.vh"

module dcp_ctrl_pins #(
  parameter LANES = 1,
  parameter RL = `DCP_RD_LAT,
  parameter BL = `DCP_BURST_LEN
) (
  // Clock and reset
  input wire CLOCK,
  input wire NRST,
  // Differential clock and control pins
  input wire CK,
  input wire CK_N,
  input wire CKE,
  input wire CS_N,
  input wire RAS_N,
  input wire CAS_N,
  input wire WE_N,
  input wire [2:0] BA,
  input wire [13:0] ADDR,
  input wire ODT,
  // Data, strobe and mask pins
  input wire [8*LANES-1:0] DQ_IN,
  output wire [8*LANES-1:0] DQ_OUT,
  output wire DQ_OE,
  input wire [LANES-1:0] DQS_IN,
  output wire [LANES-1:0] DQS_OUT,
  output wire [LANES-1:0] DQS_N_OUT,
  output wire DQS_OE,
  input wire [LANES-1:0] DM_IN,
  output wire RDQS_OUT,
  output wire RDQS_N_OUT,
  output wire RDQS_OE,
  // Termination enables
  output reg TERM_DQ_EN,
  output reg [LANES-1:0] TERM_DQS_EN,
  output reg [LANES-1:0] TERM_DM_EN,
  // Power and buffer control
  output reg INT_CLK_EN,
  output reg OUT_DRV_EN,
  output reg BUF_CLK_EN,
  output reg BUF_CMD_EN,
  output reg BUF_ODT_EN,
  output reg BUF_CKE_EN,
  output reg [1:0] PWR_STATE,
  output reg [7:0] BANK_OPEN,
  // Decoded command and write beats
  output reg CMD_VALID,
  output reg [2:0] CMD_CODE,
  output reg WR_BEAT,
  output reg [8*LANES-1:0] WR_DATA,
  output reg [LANES-1:0] WR_KEEP
);

  localparam DW = 8 * LANES;
  localparam SW = 25 + DW + 2 * LANES;
  localparam [1:0] PS_ACT = `DCP_PS_ACT;
  localparam [1:0] PS_PPD = `DCP_PS_PPD;
  localparam [1:0] PS_APD = `DCP_PS_APD;
  localparam [1:0] PS_SREF = `DCP_PS_SREF;
  localparam [3:0] BL_W = BL;

  // ****************************************
  // Pin synchronisers
  // ****************************************
  wire [SW-1:0] pins_s;
  wire ck_s, ckn_s, cke_s, cs_n_s, odt_s;
  wire [2:0] cmd_s;
  wire [2:0] ba_s;
  wire [13:0] a_s;
  wire [DW-1:0] dq_s;
  wire [LANES-1:0] dqs_s;
  wire [LANES-1:0] dm_s;

  dcp_sync #(.W(SW)) u_sync (
    .clk(CLOCK),
    .rst_n(NRST),
    .d({CK, CK_N, CKE, CS_N, RAS_N, CAS_N, WE_N, BA, ADDR, ODT,
        DQ_IN, DQS_IN, DM_IN}),
    .q(pins_s)
  );

  assign {ck_s, ckn_s, cke_s, cs_n_s, cmd_s, ba_s, a_s, odt_s,
          dq_s, dqs_s, dm_s} = pins_s;

  // ****************************************
  // Crossing detection
  // ****************************************
  reg ck_hi_p_r;
  reg ck_lo_p_r;
  reg dqs_p_r;
  wire ck_hi = ck_s & ~ckn_s;
  wire ck_lo = ~ck_s & ckn_s;
  // Clock buffer is off in self refresh, so no crossings are seen
  wire clk_alive = PWR_STATE != PS_SREF;
  wire rise = clk_alive & ck_hi & ~ck_hi_p_r;
  wire fall = clk_alive & ck_lo & ~ck_lo_p_r;
  wire dqs_edge = dqs_s[0] ^ dqs_p_r;

  always @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      ck_hi_p_r <= 1'h0;
      ck_lo_p_r <= 1'h0;
      dqs_p_r <= 1'h0;
    end else begin
      ck_hi_p_r <= ck_hi;
      ck_lo_p_r <= ck_lo;
      dqs_p_r <= dqs_s[0];
    end
  end

  // ****************************************
  // Command decode
  // ****************************************
  reg [13:0] emr_r;
  wire rdqs_en = (LANES == 1) & emr_r[`DCP_EMR_RDQS];
  wire rtt_en = emr_r[`DCP_EMR_RTT0] | emr_r[`DCP_EMR_RTT1];
  // Commands only run in the active state with CKE held high
  wire cmd_take = rise & (PWR_STATE == PS_ACT) & cke_s;
  wire cmd_sel = cmd_take & ~cs_n_s;
  wire is_ref = cmd_s == `DCP_CMD_REF;
  wire all_idle = BANK_OPEN == 8'h00;

  reg [7:0] bank_nxt;
  reg [1:0] ps_nxt;

  always @* begin
    bank_nxt = BANK_OPEN;
    if (cmd_sel) begin
      case (cmd_s)
        `DCP_CMD_ACT: bank_nxt[ba_s] = 1'h1;
        `DCP_CMD_PRE: begin
          if (a_s[`DCP_A_AUTOPRE])
            bank_nxt = 8'h00;
          else
            bank_nxt[ba_s] = 1'h0;
        end
        `DCP_CMD_RD, `DCP_CMD_WR: begin
          if (a_s[`DCP_A_AUTOPRE])
            bank_nxt[ba_s] = 1'h0;
        end
        default: bank_nxt = BANK_OPEN;
      endcase
    end
  end

  // ****************************************
  // Power state machine
  // ****************************************
  always @* begin
    ps_nxt = PWR_STATE;
    case (PWR_STATE)
      PS_ACT: begin
        if (rise && !cke_s) begin
          if (!cs_n_s && is_ref && all_idle)
            ps_nxt = PS_SREF;
          else if (all_idle)
            ps_nxt = PS_PPD;
          else
            ps_nxt = PS_APD;
        end
      end
      PS_PPD, PS_APD: begin
        if (rise && cke_s)
          ps_nxt = PS_ACT;
      end
      PS_SREF: begin
        // No CK edge needed: the clock may be stopped here
        if (cke_s)
          ps_nxt = PS_ACT;
      end
      default: ps_nxt = PS_ACT;
    endcase
  end

  always @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      PWR_STATE <= PS_ACT;
      BANK_OPEN <= 8'h00;
      emr_r <= `DCP_EMR_RST;
      CMD_VALID <= 1'h0;
      CMD_CODE <= `DCP_CMD_NOP;
      INT_CLK_EN <= 1'h1;
      OUT_DRV_EN <= 1'h1;
      BUF_CLK_EN <= 1'h1;
      BUF_CMD_EN <= 1'h1;
      BUF_ODT_EN <= 1'h1;
      BUF_CKE_EN <= 1'h1;
    end else begin
      PWR_STATE <= ps_nxt;
      BANK_OPEN <= bank_nxt;
      CMD_VALID <= cmd_sel;
      CMD_CODE <= cmd_sel ? cmd_s : `DCP_CMD_NOP;
      if (cmd_sel && cmd_s == `DCP_CMD_MRS && ba_s == `DCP_BA_EMR1)
        emr_r <= a_s;
      INT_CLK_EN <= ps_nxt == PS_ACT;
      OUT_DRV_EN <= ps_nxt == PS_ACT;
      BUF_CMD_EN <= ps_nxt == PS_ACT;
      BUF_CLK_EN <= ps_nxt != PS_SREF;
      BUF_ODT_EN <= ps_nxt != PS_SREF;
      BUF_CKE_EN <= 1'h1;
    end
  end

  // ****************************************
  // On-die termination
  // ****************************************
  always @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      TERM_DQ_EN <= 1'h0;
      TERM_DQS_EN <= {LANES{1'h0}};
      TERM_DM_EN <= {LANES{1'h0}};
    end else if (PWR_STATE == PS_SREF) begin
      TERM_DQ_EN <= 1'h0;
      TERM_DQS_EN <= {LANES{1'h0}};
      TERM_DM_EN <= {LANES{1'h0}};
    end else if (rise) begin
      // Sampled in power-down too, its buffer stays alive
      TERM_DQ_EN <= odt_s & rtt_en;
      TERM_DQS_EN <= {LANES{odt_s & rtt_en}};
      TERM_DM_EN <= {LANES{odt_s & rtt_en}};
    end
  end

  // ****************************************
  // Read burst
  // ****************************************
  wire rd_dqs;
  wire rd_start = cmd_sel & (cmd_s == `DCP_CMD_RD);
  // Zero-extended so the x16 seed never reads past the address bits
  wire [DW+13:0] seed_w = {{DW{1'h0}}, a_s};

  dcp_rd_burst #(.DW(DW), .RL(RL), .BL(BL)) u_rd (
    .clk(CLOCK),
    .rst_n(NRST),
    .rise(rise),
    .fall(fall),
    .start(rd_start),
    .seed(seed_w[DW-1:0]),
    .rdqs_en(rdqs_en),
    .dq_r(DQ_OUT),
    .dq_oe_r(DQ_OE),
    .dqs_r(rd_dqs),
    .rdqs_oe_r(RDQS_OE)
  );

  // Every lane strobe and the read strobe share one flop
  assign DQS_OUT = {LANES{rd_dqs}};
  assign DQS_N_OUT = ~DQS_OUT;
  assign DQS_OE = DQ_OE;
  assign RDQS_OUT = rd_dqs;
  assign RDQS_N_OUT = ~rd_dqs;

  // ****************************************
  // Write beats
  // ****************************************
  reg wr_open_r;
  reg [3:0] wr_cnt_r;

  always @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      wr_open_r <= 1'h0;
      wr_cnt_r <= 4'h0;
      WR_BEAT <= 1'h0;
      WR_DATA <= {DW{1'h0}};
      WR_KEEP <= {LANES{1'h0}};
    end else begin
      WR_BEAT <= 1'h0;
      if (cmd_sel && cmd_s == `DCP_CMD_WR) begin
        wr_open_r <= 1'h1;
        wr_cnt_r <= 4'h0;
      end else if (wr_open_r && dqs_edge) begin
        // Lower strobe times the whole word at every lane count
        WR_BEAT <= 1'h1;
        WR_DATA <= dq_s;
        // Mask sampled on both strobe edges, ignored in RDQS mode
        WR_KEEP <= rdqs_en ? {LANES{1'h1}} : ~dm_s;
        wr_cnt_r <= wr_cnt_r + 4'h1;
        if (wr_cnt_r == BL_W - 4'h1)
          wr_open_r <= 1'h0;
      end
    end
  end

endmodule // dcp_ctrl_pins

/* verilog/dcp_defines.vh */
`ifndef DCP_DEFINES_VH
`define DCP_DEFINES_VH

// ****************************************
// Command codes {ras_n, cas_n, we_n}
// ****************************************
`define DCP_CMD_MRS 3'h0
`define DCP_CMD_REF 3'h1
`define DCP_CMD_PRE 3'h2
`define DCP_CMD_ACT 3'h3
`define DCP_CMD_WR 3'h4
`define DCP_CMD_RD 3'h5
`define DCP_CMD_NOP 3'h7

// ****************************************
// Power states
// ****************************************
`define DCP_PS_ACT 2'h0
`define DCP_PS_PPD 2'h1
`define DCP_PS_APD 2'h2
`define DCP_PS_SREF 2'h3

// ****************************************
// Mode register fields
// ****************************************
`define DCP_BA_EMR1 3'h1
`define DCP_EMR_RTT0 2
`define DCP_EMR_RTT1 6
`define DCP_EMR_RDQS 11
`define DCP_A_AUTOPRE 10
`define DCP_EMR_RST 14'h0000

// ****************************************
// Burst timing, in CK periods and beats
// ****************************************
`define DCP_RD_LAT 3
`define DCP_BURST_LEN 4

`endif

/* verilog/dcp_rd_burst.v */
// ****************************************
// Read burst: data and strobe on both CK crossings
// ****************************************
module dcp_rd_burst #(
  parameter DW = 8,
  parameter RL = 3,
  parameter BL = 4
) (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // CK crossings and request
  input wire rise,
  input wire fall,
  input wire start,
  input wire [DW-1:0] seed,
  input wire rdqs_en,
  // Pin drive
  output reg [DW-1:0] dq_r,
  output reg dq_oe_r,
  output reg dqs_r,
  output reg rdqs_oe_r
);

  localparam [3:0] RL_M1 = RL - 1;
  localparam [3:0] BL_W = BL;

  reg busy_r;
  reg drive_r;
  reg [3:0] lat_r;
  reg [3:0] beat_r;
  reg [DW-1:0] base_r;
  wire [DW-1:0] next_word = base_r + {{(DW-4){1'h0}}, beat_r};

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_r <= 1'h0;
      drive_r <= 1'h0;
      lat_r <= 4'h0;
      beat_r <= 4'h0;
      base_r <= {DW{1'h0}};
      dq_r <= {DW{1'h0}};
      dq_oe_r <= 1'h0;
      dqs_r <= 1'h0;
      rdqs_oe_r <= 1'h0;
    end else if (start) begin
      // A new read restarts the burst
      busy_r <= 1'h1;
      drive_r <= 1'h0;
      lat_r <= RL_M1;
      beat_r <= 4'h0;
      base_r <= seed;
    end else if (busy_r && (rise || fall)) begin
      if (!drive_r) begin
        if (rise && lat_r == 4'h0) begin
          drive_r <= 1'h1;
          dq_oe_r <= 1'h1;
          rdqs_oe_r <= rdqs_en;
          dqs_r <= 1'h1;
          dq_r <= base_r;
          beat_r <= 4'h1;
        end else if (rise) begin
          lat_r <= lat_r - 4'h1;
        end
      end else if (beat_r == BL_W) begin
        busy_r <= 1'h0;
        drive_r <= 1'h0;
        dq_oe_r <= 1'h0;
        rdqs_oe_r <= 1'h0;
        dqs_r <= 1'h0;
      end else begin
        // Edge aligned: strobe follows the crossing direction
        dq_r <= next_word;
        dqs_r <= rise;
        beat_r <= beat_r + 4'h1;
      end
    end
  end

endmodule // dcp_rd_burst

/* verilog/dcp_sync.v */
// ****************************************
// Two-stage synchroniser for pin inputs
// ****************************************
module dcp_sync #(
  parameter W = 1
) (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Data
  input wire [W-1:0] d,
  output reg [W-1:0] q
);

  reg [W-1:0] meta_r;

  // First stage feeds only the second stage
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= {W{1'h0}};
      q <= {W{1'h0}};
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end

endmodule // dcp_sync
